// [gain_ctl_pkg.sv]
// Constants shared by the automatic gain control block.
package gain_ctl_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
	localparam logic [3:0] OFS_IRQ_MASK = 4'hc;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_AUTO_OFF = 8;
	localparam int CTRL_OVERSHOOT_OFF = 9;
	localparam int CTRL_BACKOFF_OFF = 10;
	localparam int CTRL_KEEP_REG = 11;
	localparam int ST_SAFE = 8;
	localparam int ST_DRIVE = 9;
	localparam int ST_DONE = 10;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_AT_MAX = 1;
	localparam int IRQ_AT_MIN = 2;
	localparam int IRQ_SAFE = 3;
	localparam int IRQ_W = 4;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [11:0] CTRL_RST = 12'h000;
	localparam logic [3:0] IRQ_MASK_RST = 4'h0;
	localparam logic [6:0] GAIN_RST = 7'h00;
	// ----------------------------------------------------------------
	// Comparator level indices, per channel
	// ----------------------------------------------------------------
	localparam int LVL_LIMIT_L = 0;
	localparam int LVL_REG_L = 1;
	localparam int LVL_HALF_H = 2;
	localparam int LVL_REG_H = 3;
	localparam int LVL_LIMIT_H = 4;
	localparam int LVL_N = 5;
	// ----------------------------------------------------------------
	// Gain figures and timing
	// ----------------------------------------------------------------
	localparam logic [7:0] GAIN_MAX = 8'h6d;
	localparam logic [7:0] GAIN_MIN = 8'h00;
	localparam logic [7:0] BOOST_STEPS = 8'h04;
	localparam logic [7:0] BACKOFF_STEPS = 8'h12;
	localparam logic [7:0] REG_STEP = 8'h01;
	localparam logic [7:0] LIMIT_STEP = 8'h08;
	localparam int CLK_MHZ = 100;
	localparam int HIZ_TIME_US = 3000;
	localparam int HIZ_CYCLES = HIZ_TIME_US * CLK_MHZ;
	localparam int REG_PERIOD_CYCLES = 1000;
	localparam int LIMIT_PERIOD_CYCLES = 250;
endpackage

// [gain_ctl.sv]
// Automatic gain control for the sine and cosine receive channels.
`timescale 1ns/10ps
module gain_ctl #(
	parameter int HIZ_CYCLES = gain_ctl_pkg::HIZ_CYCLES,
	parameter int REG_PERIOD = gain_ctl_pkg::REG_PERIOD_CYCLES,
	parameter int LIMIT_PERIOD = gain_ctl_pkg::LIMIT_PERIOD_CYCLES,
	parameter int SAFE_N = 10
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [9:0] cmp_i,
	input wire logic [SAFE_N-1:0] safe_cond_i,
	input wire logic sig_fail_i,
	output logic [6:0] gain_o,
	output logic out_drive_o,
	output logic operational_o,
	output logic irq_o
);
	typedef enum logic [2:0] {ST_RAMP, ST_BOOST, ST_BACKOFF, ST_FIXED, ST_REGULATE} agc_state_t;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [9:0] cmp_m;
	logic [9:0] cmp_s;
	logic [SAFE_N-1:0] safe_m;
	logic [SAFE_N-1:0] safe_s;
	logic sig_m;
	logic sig_s;
	always_ff @(posedge clk_i)
	begin
		cmp_m <= cmp_i;
		cmp_s <= cmp_m;
		safe_m <= safe_cond_i;
		safe_s <= safe_m;
		sig_m <= sig_fail_i;
		sig_s <= sig_m;
	end

	// ----------------------------------------------------------------
	// Comparator combination over both channels
	// ----------------------------------------------------------------
	logic [gain_ctl_pkg::LVL_N-1:0] any_above;
	logic [gain_ctl_pkg::LVL_N-1:0] both_below;
	genvar lv;
	generate
		for (lv = 0; lv < gain_ctl_pkg::LVL_N; lv++)
		begin : g_lvl
			assign any_above[lv] = cmp_s[lv] | cmp_s[lv + gain_ctl_pkg::LVL_N];
			assign both_below[lv] = ~any_above[lv];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Registers and bus decode
	// ----------------------------------------------------------------
	logic [11:0] ctrl;
	logic [gain_ctl_pkg::IRQ_W-1:0] irq_stat;
	logic [gain_ctl_pkg::IRQ_W-1:0] irq_mask;
	logic [6:0] gain;
	logic done;
	agc_state_t state;
	wire bus_req = cyc_i & stb_i & ~ack_o;
	wire wr = bus_req & we_i;
	wire wr_ctrl = wr & (adr_i == gain_ctl_pkg::OFS_CTRL);
	wire wr_stat = wr & (adr_i == gain_ctl_pkg::OFS_IRQ_STAT) & sel_i[0];
	wire wr_mask = wr & (adr_i == gain_ctl_pkg::OFS_IRQ_MASK) & sel_i[0];
	wire auto_gain_off = ctrl[gain_ctl_pkg::CTRL_AUTO_OFF];
	wire startup_overshoot_off = ctrl[gain_ctl_pkg::CTRL_OVERSHOOT_OFF];
	wire startup_backoff_off = ctrl[gain_ctl_pkg::CTRL_BACKOFF_OFF];
	wire keep_regulating = ctrl[gain_ctl_pkg::CTRL_KEEP_REG];
	wire [6:0] fixed_gain_code = ctrl[6:0];
	wire freeze = |safe_s;
	wire safe = freeze | sig_s;
	wire [31:0] status_word = {21'h000000, done, out_drive_o, safe, 1'b0, gain};
	logic [31:0] rd_data;
	always_comb
	begin
		case (adr_i)
			gain_ctl_pkg::OFS_CTRL: rd_data = {20'h00000, ctrl};
			gain_ctl_pkg::OFS_STATUS: rd_data = status_word;
			gain_ctl_pkg::OFS_IRQ_STAT: rd_data = {28'h0000000, irq_stat};
			gain_ctl_pkg::OFS_IRQ_MASK: rd_data = {28'h0000000, irq_mask};
			default: rd_data = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end
		else
		begin
			ack_o <= bus_req;
			dat_o <= bus_req ? rd_data : 32'h00000000;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl <= gain_ctl_pkg::CTRL_RST;
		else if (wr_ctrl)
		begin
			if (sel_i[0])
				ctrl[7:0] <= dat_i[7:0];
			if (sel_i[1])
				ctrl[11:8] <= dat_i[11:8];
		end
	end

	// ----------------------------------------------------------------
	// Evaluation period tickers
	// ----------------------------------------------------------------
	logic [31:0] reg_cnt;
	logic [31:0] lim_cnt;
	wire reg_tick = (reg_cnt == 32'(REG_PERIOD - 1));
	wire lim_tick = (lim_cnt == 32'(LIMIT_PERIOD - 1));
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			reg_cnt <= 32'h00000000;
			lim_cnt <= 32'h00000000;
		end
		else
		begin
			reg_cnt <= reg_tick ? 32'h00000000 : reg_cnt + 32'h00000001;
			lim_cnt <= lim_tick ? 32'h00000000 : lim_cnt + 32'h00000001;
		end
	end

	// ----------------------------------------------------------------
	// Gain arithmetic with saturation
	// ----------------------------------------------------------------
	function automatic logic [6:0] gain_up(input logic [6:0] g, input logic [7:0] d);
		logic [7:0] s;
		s = {1'b0, g} + d;
		if (s > gain_ctl_pkg::GAIN_MAX)
			s = gain_ctl_pkg::GAIN_MAX;
		return s[6:0];
	endfunction

	function automatic logic [6:0] gain_down(input logic [6:0] g, input logic [7:0] d);
		logic [7:0] s;
		s = {1'b0, g};
		if (s < gain_ctl_pkg::GAIN_MIN + d)
			s = gain_ctl_pkg::GAIN_MIN + d;
		s = s - d;
		return s[6:0];
	endfunction

	// Regulation mode gates: single count moves.
	wire reg_inc = both_below[gain_ctl_pkg::LVL_REG_L];
	wire reg_dec = any_above[gain_ctl_pkg::LVL_REG_H];
	// Step mode gates: large moves outside the limit levels.
	wire lim_inc = both_below[gain_ctl_pkg::LVL_LIMIT_L];
	wire lim_dec = any_above[gain_ctl_pkg::LVL_LIMIT_H];
	wire half_hit = any_above[gain_ctl_pkg::LVL_HALF_H];
	wire at_max = ({1'b0, gain} == gain_ctl_pkg::GAIN_MAX);

	// ----------------------------------------------------------------
	// Startup and regulation state machine
	// ----------------------------------------------------------------
	agc_state_t next_state;
	logic [6:0] next_gain;
	always_comb
	begin
		next_state = state;
		next_gain = gain;
		case (state)
			ST_RAMP:
				if (reg_tick)
				begin
					if (half_hit | at_max)
						next_state = startup_overshoot_off ? ST_BACKOFF : ST_BOOST;
					else
						next_gain = gain_up(gain, gain_ctl_pkg::REG_STEP);
				end
			ST_BOOST:
				if (reg_tick)
				begin
					next_gain = gain_up(gain, gain_ctl_pkg::BOOST_STEPS);
					next_state = ST_BACKOFF;
				end
			ST_BACKOFF:
				if (reg_tick)
				begin
					if (!startup_backoff_off)
						next_gain = gain_down(gain, gain_ctl_pkg::BACKOFF_STEPS);
					next_state = keep_regulating ? ST_REGULATE : ST_FIXED;
				end
			ST_FIXED:
				next_state = ST_FIXED;
			ST_REGULATE:
				if (lim_tick & lim_dec)
					next_gain = gain_down(gain, gain_ctl_pkg::LIMIT_STEP);
				else if (lim_tick & lim_inc)
					next_gain = gain_up(gain, gain_ctl_pkg::LIMIT_STEP);
				else if (reg_tick & reg_dec)
					next_gain = gain_down(gain, gain_ctl_pkg::REG_STEP);
				else if (reg_tick & reg_inc)
					next_gain = gain_up(gain, gain_ctl_pkg::REG_STEP);
			default:
				next_state = ST_RAMP;
		endcase
	end

	wire run = ~auto_gain_off & ~freeze;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state <= ST_RAMP;
			gain <= gain_ctl_pkg::GAIN_RST;
		end
		else if (run)
		begin
			state <= next_state;
			gain <= next_gain;
		end
	end

	wire done_now = (state == ST_FIXED) | (state == ST_REGULATE);
	assign done = done_now;

	// ----------------------------------------------------------------
	// Output drive
	// ----------------------------------------------------------------
	logic [31:0] hiz_cnt;
	wire hiz_end = (hiz_cnt == 32'(HIZ_CYCLES - 1));
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hiz_cnt <= 32'h00000000;
			out_drive_o <= 1'b0;
			gain_o <= gain_ctl_pkg::GAIN_RST;
			operational_o <= 1'b0;
		end
		else
		begin
			if (!out_drive_o)
				hiz_cnt <= hiz_cnt + 32'h00000001;
			if (hiz_end)
				out_drive_o <= 1'b1;
			gain_o <= auto_gain_off ? fixed_gain_code : gain;
			operational_o <= ~safe;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	logic done_d;
	logic safe_d;
	logic at_max_d;
	logic at_min_d;
	wire at_min = (gain == 7'h00);
	wire [gain_ctl_pkg::IRQ_W-1:0] ev = {safe & ~safe_d, at_min & ~at_min_d,
		at_max & ~at_max_d, done & ~done_d};
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_stat <= '0;
			irq_mask <= gain_ctl_pkg::IRQ_MASK_RST;
			done_d <= 1'b0;
			safe_d <= 1'b0;
			at_max_d <= 1'b0;
			at_min_d <= 1'b1;
			irq_o <= 1'b0;
		end
		else
		begin
			irq_stat <= (irq_stat & ~(wr_stat ? dat_i[3:0] : 4'h0)) | ev;
			if (wr_mask)
				irq_mask <= dat_i[3:0];
			done_d <= done;
			safe_d <= safe;
			at_max_d <= at_max;
			at_min_d <= at_min;
			irq_o <= |(irq_stat & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_gain_max;
		{1'b0, gain} <= gain_ctl_pkg::GAIN_MAX;
	endproperty
	a_gain_max: assert property (p_gain_max) else $error("gain above maximum");

	property p_no_wrap_down;
		(run && state == ST_REGULATE && gain < 7'h08) |=> !(gain > 7'h60);
	endproperty
	a_no_wrap_down: assert property (p_no_wrap_down) else $error("gain wrapped below zero");

	property p_freeze;
		(freeze && !$past(run)) |=> $stable(gain) && $stable(state);
	endproperty
	a_freeze: assert property (p_freeze) else $error("gain moved while frozen");

	property p_tick_only;
		(gain != $past(gain)) |-> $past(reg_tick || lim_tick);
	endproperty
	a_tick_only: assert property (p_tick_only) else $error("gain changed off tick");

	property p_fixed_hold;
		(state == ST_FIXED) |=> (state == ST_FIXED) && $stable(gain);
	endproperty
	a_fixed_hold: assert property (p_fixed_hold) else $error("fixed gain changed");

	property p_fixed_code;
		auto_gain_off |=> (gain_o == $past(fixed_gain_code));
	endproperty
	a_fixed_code: assert property (p_fixed_code) else $error("fixed gain not applied");

	property p_boost;
		(run && state == ST_BOOST && reg_tick && gain < 7'h60) |=> gain == $past(gain) + 7'h04;
	endproperty
	a_boost: assert property (p_boost) else $error("boost not four steps");

	property p_backoff;
		(run && state == ST_BACKOFF && reg_tick && !startup_backoff_off && gain > 7'h12)
			|=> gain == $past(gain) - 7'h12;
	endproperty
	a_backoff: assert property (p_backoff) else $error("backoff not eighteen");

	property p_drive_late;
		!out_drive_o |-> (hiz_cnt < 32'(HIZ_CYCLES));
	endproperty
	a_drive_late: assert property (p_drive_late) else $error("high impedance overran");

	property p_drive_on;
		hiz_end |=> out_drive_o [*2];
	endproperty
	a_drive_on: assert property (p_drive_on) else $error("outputs not driven");

	property p_mode;
		!$past(rst_i) |-> (operational_o == !$past(safe));
	endproperty
	a_mode: assert property (p_mode) else $error("mode not exclusive");

	property p_ack;
		(cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus ack not single");

	property p_auto_gain;
		!auto_gain_off |=> (gain_o == $past(gain));
	endproperty
	a_auto_gain: assert property (p_auto_gain) else $error("auto gain not applied");

	c_done: cover property (state == ST_BACKOFF ##1 state == ST_REGULATE);
	c_freeze: cover property (freeze && state == ST_REGULATE ##1 !freeze);
	c_max: cover property (at_max && state == ST_REGULATE);
endmodule

// [rx_chain_model.sv]
// Behavioural receive chain with amplitude comparators for the gain block.
`timescale 1ns/10ps
module rx_chain_model (
	input wire logic [6:0] gain_i,
	input wire logic [9:0] ks_i,
	input wire logic [9:0] kc_i,
	output logic [9:0] cmp_o
);
	localparam int LVL [5] = '{40, 140, 280, 560, 720};
	int amp_s;
	int amp_c;
	// ----
	// Comparators
	// ----
	// Both channels scale with the one shared gain, levels in rising order.
	always_comb
	begin
		amp_s = int'(gain_i) * int'(ks_i);
		amp_c = int'(gain_i) * int'(kc_i);
		for (int i = 0; i < 5; i++)
		begin
			cmp_o[i] = amp_s > LVL[i];
			cmp_o[i + 5] = amp_c > LVL[i];
		end
	end
endmodule

// [gain_ctl_test.sv]
// Self-checking bench for the automatic gain control block.
`timescale 1ns/10ps
module gain_ctl_test;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [3:0] adr_i = 4'h0;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic ack_o;
	logic [9:0] cmp_i;
	logic [9:0] safe_cond_i = 10'h000;
	logic sig_fail_i = 1'b0;
	logic [6:0] gain_o;
	logic out_drive_o;
	logic operational_o;
	logic irq_o;
	logic [9:0] ks = 10'h000;
	logic [9:0] kc = 10'h000;
	logic [31:0] rd;
	int n;
	int failures = 0;
	int comparisons = 0;
	// Startup cases: sine and cosine coupling, control word, final gain, events.
	logic [9:0] cs [7] = '{10'h00b, 10'h000, 10'h00b, 10'h00b, 10'h000, 10'h000, 10'h12c};
	logic [9:0] cc [7] = '{10'h000, 10'h00b, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000};
	logic [11:0] cw [7] = '{12'h000, 12'h200, 12'h400, 12'h600, 12'h000, 12'h400, 12'h000};
	logic [6:0] cg [7] = '{7'h0c, 7'h08, 7'h1e, 7'h1a, 7'h5b, 7'h6d, 7'h00};
	logic [3:0] ce [7] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h3, 4'h3, 4'h5};
	always #5 clk_i = ~clk_i;
	gain_ctl #(.HIZ_CYCLES(50), .REG_PERIOD(8), .LIMIT_PERIOD(4)) gain_ctl_inst (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.cmp_i(cmp_i), .safe_cond_i(safe_cond_i), .sig_fail_i(sig_fail_i),
		.gain_o(gain_o), .out_drive_o(out_drive_o), .operational_o(operational_o),
		.irq_o(irq_o));
	rx_chain_model rx_chain_model_inst (.gain_i(gain_o), .ks_i(ks), .kc_i(kc), .cmp_o(cmp_i));
	// ----
	// Tasks
	// ----
	task automatic wrap_up();
		$display("Counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	function automatic logic [31:0] g();
		return {25'h0, gain_o};
	endfunction
	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	task automatic amp(input logic [9:0] v);
		ks <= v;
		kc <= v;
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'hf;
		dat_i <= d;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (ack_o !== 1'b1 && k < 20);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (k >= 20)
		begin
			failures++;
			wrap_up();
		end
		@(posedge clk_i);
	endtask
	task automatic restart(input logic [9:0] s, input logic [9:0] c, input logic [31:0] w);
		rst_i <= 1'b1;
		ks <= s;
		kc <= c;
		tick(12);
		rst_i <= 1'b0;
		tick(1);
		chk("gain after reset", 32'h0, g());
		wb(1'b1, gain_ctl_pkg::OFS_CTRL, w);
		tick(40);
		chk("drive in hold", 32'h0, {31'h0, out_drive_o});
		tick(15);
		chk("drive after hold", 32'h1, {31'h0, out_drive_o});
	endtask
	task automatic wait_done();
		int k = 0;
		do
		begin
			wb(1'b0, gain_ctl_pkg::OFS_STATUS, 32'h0);
			k++;
		end
		while (rd[gain_ctl_pkg::ST_DONE] !== 1'b1 && k < 500);
		if (k >= 500)
		begin
			failures++;
			wrap_up();
		end
		tick(4);
	endtask
	// ----
	// Sequence
	// ----
	initial
	begin
		for (int i = 0; i < 7; i++)
		begin
			restart(cs[i], cc[i], {20'h0, cw[i]});
			wait_done();
			chk("startup gain", {25'h0, cg[i]}, g());
			amp(10'h12c);
			tick(40);
			chk("gain kept", {25'h0, cg[i]}, g());
			wb(1'b0, gain_ctl_pkg::OFS_IRQ_STAT, 32'h0);
			chk("events", {28'h0, ce[i]}, rd);
			$display("startup case %0d done", i);
		end
		restart(10'h00b, 10'h00b, 32'h800);
		wait_done();
		tick(40);
		chk("regulated up", 32'h0d, g());
		amp(10'h002);
		tick(700);
		chk("limit raise", 32'h47, g());
		amp(10'h00b);
		tick(300);
		chk("limit lower", 32'h32, g());
		$display("regulation test done");
		for (int k = 0; k < 10; k++)
		begin
			safe_cond_i <= 10'h001 << k;
			tick(6);
			amp(10'h002);
			tick(14);
			chk("safe state", 32'h0, {31'h0, operational_o});
		end
		chk("frozen gain", 32'h32, g());
		safe_cond_i <= 10'h000;
		n = 0;
		while (gain_o === 7'h32 && n < 40)
		begin
			tick(1);
			n++;
		end
		if (n >= 40)
		begin
			failures++;
			wrap_up();
		end
		chk("resumed gain", 32'h33, g());
		chk("operational", 32'h1, {31'h0, operational_o});
		sig_fail_i <= 1'b1;
		tick(30);
		chk("signature fault state", 32'h0, {31'h0, operational_o});
		chk("gain moves on", 32'h1, {31'h0, gain_o > 7'h33});
		wb(1'b0, gain_ctl_pkg::OFS_STATUS, 32'h0);
		chk("status safe", 32'h1, {31'h0, rd[gain_ctl_pkg::ST_SAFE]});
		chk("status drive", 32'h1, {31'h0, rd[gain_ctl_pkg::ST_DRIVE]});
		sig_fail_i <= 1'b0;
		tick(6);
		$display("safe state test done");
		chk("irq masked", 32'h0, {31'h0, irq_o});
		wb(1'b1, gain_ctl_pkg::OFS_IRQ_MASK, 32'h8);
		tick(3);
		chk("irq raised", 32'h1, {31'h0, irq_o});
		wb(1'b0, gain_ctl_pkg::OFS_IRQ_MASK, 32'h0);
		chk("mask readback", 32'h8, rd);
		wb(1'b1, gain_ctl_pkg::OFS_IRQ_STAT, 32'hf);
		tick(3);
		chk("irq cleared", 32'h0, {31'h0, irq_o});
		wb(1'b0, gain_ctl_pkg::OFS_IRQ_STAT, 32'h0);
		chk("events cleared", 32'h0, rd);
		wb(1'b0, 4'h2, 32'h0);
		chk("unmapped read", 32'h0, rd);
		$display("register test done");
		wb(1'b1, gain_ctl_pkg::OFS_CTRL, 32'h955);
		tick(4);
		chk("fixed code gain", 32'h55, g());
		tick(40);
		chk("fixed code held", 32'h55, g());
		$display("fixed gain test done");
		wrap_up();
	end
endmodule
